// ### acc_pkg.sv
`default_nettype none
package acc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int ACC_ADDR_W = 8;
  localparam logic [7:0] ACC_CTL0_OFS = 8'h00;
  localparam logic [7:0] ACC_CTL1_OFS = 8'h04;
  localparam logic [7:0] ACC_RES_HI_OFS = 8'h08;
  localparam logic [7:0] ACC_RES_LO_OFS = 8'h0C;
  localparam logic [7:0] ACC_FIFO_OFS = 8'h10;
  localparam logic [7:0] ACC_STAT_OFS = 8'h14;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int ACC_CHAN_LSB = 0;
  localparam int ACC_REFLO_BIT = 4;
  localparam int ACC_REFPIN_BIT = 5;
  localparam int ACC_REPEAT_BIT = 6;
  localparam int ACC_START_BIT = 7;
  localparam int ACC_BUF_LSB = 0;
  localparam int ACC_STANDBY_BIT = 3;
  localparam int ACC_REFHI_BIT = 7;
  localparam int ACC_FIFO_VALID_BIT = 31;
  localparam int ACC_STAT_PWR_BIT = 3;
  localparam int ACC_STAT_STALL_BIT = 4;
  localparam int ACC_STAT_LEVEL_LSB = 8;
  localparam logic [3:0] ACC_CHAN_RST = 4'h0;
  localparam logic [2:0] ACC_BUF_RST = 3'h0;
  localparam logic [1:0] ACC_REF_OFF = 2'h0;
  // ****************************************
  // Timing, in system clock cycles; then timer and result widths and buffer depth
  // ****************************************
  localparam int ACC_FIRST_CONV_CYC = 5129;
  localparam int ACC_PWRUP_CYC = 40;
  localparam int ACC_REPEAT_CYC = 256;
  localparam int ACC_TMR_W = 13;
  localparam int ACC_RES_W = 13;
  localparam int ACC_FIFO_DEPTH = 16;
  // ****************************************
  // Operating mode
  // ****************************************
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_FIRST = 3'b010,
    ACC_CONT = 3'b100
  } acc_mode_t;
endpackage : acc_pkg
`default_nettype wire

// ### acc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module acc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] head;
  } acc_fifo_st_t;

  acc_fifo_st_t q, d;
  logic push, pop;

  // Head word is re-registered every cycle so read data leave a flop
  always_comb begin
    d = q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.head = d.mem[d.rp];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.head;
  assign level = q.cnt;
endmodule : acc_fifo
`default_nettype wire

// ### acc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module acc_timer #(
  parameter int W = 13
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } acc_timer_st_t;

  acc_timer_st_t q, d;

  // Stays at zero once there, so a stalled conversion waits in place
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign zero = q.cnt == '0;
endmodule : acc_timer
`default_nettype wire

// ### acc_ctrl.sv
// Functional notes
// - Three-bit buffer field picks single-ended/differential and buffered/unbuffered input.
// - Two-bit reference select, high bit in control 1, low bit in control 0.
// - Four-bit channel field in control 0 picks the analog source.
// - Repeat bit set to one selects continuous rather than single conversion.
// - Reference pin drive routes reference out; internal reference must be enabled.
// - Start bit written one begins conversion; control 0 fields taken in one write.
// - First result after 5129 cycles, plus 40 when powering up.
// - Start bit clears at first result and stays zero while continuous.
// - After the first, a fresh result every 256 cycles while continuous.
// - Result is 13-bit two's complement: high byte, low byte bits 7 to 3.
// - Conversion-complete request sent for the first and every later result.
// - Clearing the repeat bit ends continuous conversion.
// - No new requests while disabled; a pending one is not cleared.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int FIRST_CYC = ACC_FIRST_CONV_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ACC_RES_W-1:0] adc_sample,
  output logic adc_power,
  output logic [3:0] adc_channel,
  output logic [2:0] adc_buffer_cfg,
  output logic [1:0] adc_ref_sel,
  output logic adc_ref_out_en,
  output logic conv_done_irq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    acc_mode_t mode;
    logic [3:0] input_channel_select;
    logic ref_level_select_lo;
    logic ref_pin_drive;
    logic repeat_en;
    logic conversion_start_flag;
    logic [2:0] input_buffer_config;
    logic standby;
    logic ref_level_select_hi;
    logic powered;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic irq;
    logic [31:0] rdata;
    logic slverr;
    logic [13:0] since;
    logic [8:0] gap;
    logic stall;
    logic pu_added;
  } acc_state_t;

  acc_state_t q, d;

  localparam int FIFO_LW = $clog2(ACC_FIFO_DEPTH) + 1;

  logic acc_setup, acc_wr, conv_fire, conv_wait;
  logic tmr_load, tmr_zero;
  logic [ACC_TMR_W-1:0] tmr_val;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [ACC_RES_W-1:0] fifo_out_data;
  logic [FIFO_LW-1:0] fifo_level;

  function automatic logic acc_is_mapped(input logic [ACC_ADDR_W-1:0] a);
    acc_is_mapped = (a == ACC_CTL0_OFS) || (a == ACC_CTL1_OFS) ||
                    (a == ACC_RES_HI_OFS) || (a == ACC_RES_LO_OFS) ||
                    (a == ACC_FIFO_OFS) || (a == ACC_STAT_OFS);
  endfunction : acc_is_mapped

  // ****************************************
  // Cycle timer and result buffer
  // ****************************************
  acc_timer #(
    .W(ACC_TMR_W)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .zero(tmr_zero)
  );

  // A full buffer holds the finished conversion back until software drains it
  acc_fifo #(
    .WIDTH(ACC_RES_W),
    .DEPTH(ACC_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(conv_fire),
    .in_ready(fifo_in_ready),
    .in_data(adc_sample),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.irq = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    acc_setup = psel && !penable;
    acc_wr = psel && penable && pwrite;
    conv_wait = (q.mode != ACC_IDLE) && tmr_zero;
    conv_fire = conv_wait && fifo_in_ready;
    // Elapsed-cycle counters feed only the timing checks; both saturate
    if (q.mode != ACC_IDLE && q.since != '1) begin
      d.since = q.since + 14'h0001;
    end
    if (q.gap != '1) begin
      d.gap = q.gap + 9'h001;
    end
    // Stall stays set until the late result lands or a new start clears it
    if (conv_wait && !fifo_in_ready) begin
      d.stall = 1'b1;
    end
    if (conv_fire) begin
      d.result_high_byte = adc_sample[12:5];
      d.result_low_byte = {adc_sample[4:0], 3'h0};
      d.irq = 1'b1;
      d.conversion_start_flag = 1'b0;
      d.gap = '0;
      d.stall = 1'b0;
      if (q.mode == ACC_FIRST && !q.repeat_en) begin
        d.mode = ACC_IDLE;
      end else begin
        d.mode = ACC_CONT;
        tmr_load = 1'b1;
        tmr_val = ACC_TMR_W'(ACC_REPEAT_CYC - 1);
      end
    end
    // Read data are captured in setup so the access phase never waits
    if (acc_setup) begin
      d.slverr = !acc_is_mapped(paddr);
      d.rdata = '0;
      if (!pwrite) begin
        case (paddr)
          ACC_CTL0_OFS: begin
            d.rdata[ACC_CHAN_LSB +: 4] = q.input_channel_select;
            d.rdata[ACC_REFLO_BIT] = q.ref_level_select_lo;
            d.rdata[ACC_REFPIN_BIT] = q.ref_pin_drive;
            d.rdata[ACC_REPEAT_BIT] = q.repeat_en;
            d.rdata[ACC_START_BIT] = q.conversion_start_flag;
          end
          ACC_CTL1_OFS: begin
            d.rdata[ACC_BUF_LSB +: 3] = q.input_buffer_config;
            d.rdata[ACC_STANDBY_BIT] = q.standby;
            d.rdata[ACC_REFHI_BIT] = q.ref_level_select_hi;
          end
          ACC_RES_HI_OFS: begin
            d.rdata[7:0] = q.result_high_byte;
          end
          ACC_RES_LO_OFS: begin
            d.rdata[7:0] = q.result_low_byte;
          end
          // Valid flag lets software drain without reading the level first
          ACC_FIFO_OFS: begin
            d.rdata[ACC_FIFO_VALID_BIT] = fifo_out_valid;
            d.rdata[ACC_RES_W-1:0] = fifo_out_data;
          end
          ACC_STAT_OFS: begin
            d.rdata[2:0] = q.mode;
            d.rdata[ACC_STAT_PWR_BIT] = q.powered;
            d.rdata[ACC_STAT_STALL_BIT] = q.stall;
            d.rdata[ACC_STAT_LEVEL_LSB +: FIFO_LW] = fifo_level;
          end
          default: begin
            d.rdata = '0;
          end
        endcase
      end
    end
    if (acc_wr && paddr == ACC_CTL0_OFS) begin
      d.input_channel_select = pwdata[ACC_CHAN_LSB +: 4];
      d.ref_level_select_lo = pwdata[ACC_REFLO_BIT];
      d.ref_pin_drive = pwdata[ACC_REFPIN_BIT];
      d.repeat_en = pwdata[ACC_REPEAT_BIT];
      if (q.mode == ACC_IDLE && pwdata[ACC_START_BIT]) begin
        d.conversion_start_flag = 1'b1;
        d.mode = ACC_FIRST;
        d.since = '0;
        d.stall = 1'b0;
        d.pu_added = !q.powered;
        tmr_load = 1'b1;
        if (q.powered) begin
          tmr_val = ACC_TMR_W'(FIRST_CYC - 1);
        end else begin
          tmr_val = ACC_TMR_W'(FIRST_CYC + ACC_PWRUP_CYC - 1);
        end
      end
      // Stopping wins over a result landing in the same cycle
      if (d.mode == ACC_CONT && !pwdata[ACC_REPEAT_BIT]) begin
        d.mode = ACC_IDLE;
      end
    end
    if (acc_wr && paddr == ACC_CTL1_OFS) begin
      d.input_buffer_config = pwdata[ACC_BUF_LSB +: 3];
      d.standby = pwdata[ACC_STANDBY_BIT];
      d.ref_level_select_hi = pwdata[ACC_REFHI_BIT];
    end
    // Idle powers the converter down unless standby asks otherwise;
    // the price is the power-up delay on the next start
    d.powered = (d.mode != ACC_IDLE) || (q.powered && d.standby);
  end

  // Reset brings the block up idle with the converter powered down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= ACC_IDLE;
      q.input_channel_select <= ACC_CHAN_RST;
      q.input_buffer_config <= ACC_BUF_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign fifo_out_ready = psel && penable && !pwrite && paddr == ACC_FIFO_OFS &&
                          q.rdata[ACC_FIFO_VALID_BIT];
  assign prdata = q.rdata;
  // No wait states: read data were already captured in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && q.slverr;
  assign adc_power = q.powered;
  assign adc_channel = q.input_channel_select;
  assign adc_buffer_cfg = q.input_buffer_config;
  assign adc_ref_sel = {q.ref_level_select_hi, q.ref_level_select_lo};
  // Reference is only driven out while it is actually generated
  assign adc_ref_out_en = q.ref_pin_drive && adc_ref_sel != ACC_REF_OFF;
  assign conv_done_irq = q.irq;

  // ****************************************
  // Checks
  // ****************************************
  // Timing checks skip stalled results, whose cadence restarts late
  a_buf_field: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL1_OFS) |=> adc_buffer_cfg == $past(pwdata[2:0]))
    else $error("buffer config not taken from write");

  a_ref_pair: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL0_OFS) |=> adc_ref_sel[0] == $past(pwdata[ACC_REFLO_BIT]))
    else $error("reference low bit not taken from control 0");

  a_chan_select: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL0_OFS) |=> adc_channel == $past(pwdata[3:0]))
    else $error("channel not taken from write");

  a_ref_pin: assert property (@(posedge clock) disable iff (!rst_n)
    adc_ref_out_en |-> adc_ref_sel != ACC_REF_OFF)
    else $error("reference driven out while disabled");

  a_start_begin: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL0_OFS && pwdata[ACC_START_BIT] && q.mode == ACC_IDLE)
    |=> q.mode == ACC_FIRST && q.conversion_start_flag && adc_power)
    else $error("start write did not begin conversion");

  a_first_time: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_fire && q.mode == ACC_FIRST && !q.stall) |->
    int'(q.since) == (q.pu_added ? FIRST_CYC + ACC_PWRUP_CYC - 1 : FIRST_CYC - 1))
    else $error("first conversion time wrong");

  a_start_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (q.mode == ACC_CONT) |-> !q.conversion_start_flag)
    else $error("start bit set during continuous operation");

  a_cont_enter: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_fire && q.mode == ACC_FIRST && q.repeat_en && !acc_wr) |=>
    q.mode == ACC_CONT && conv_done_irq)
    else $error("continuous mode not entered");

  a_cadence: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_fire && q.mode == ACC_CONT && !q.stall) |-> int'(q.gap) == ACC_REPEAT_CYC - 1)
    else $error("continuous cadence wrong");

  a_result_irq: assert property (@(posedge clock) disable iff (!rst_n)
    conv_fire |=> conv_done_irq &&
    {q.result_high_byte, q.result_low_byte[7:3]} == $past(adc_sample) ##1 !conv_done_irq)
    else $error("result and request not written together");

  a_stop: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL0_OFS && !pwdata[ACC_REPEAT_BIT] && q.mode == ACC_CONT)
    |=> q.mode == ACC_IDLE ##1 !conv_done_irq)
    else $error("continuous operation not stopped");

  a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (q.mode == ACC_IDLE) |=> !conv_done_irq)
    else $error("request raised while disabled");

  a_irq_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    conv_done_irq |=> !conv_done_irq)
    else $error("request longer than one cycle");

  a_low_pad: assert property (@(posedge clock) disable iff (!rst_n)
    conv_done_irq |-> q.result_low_byte[2:0] == 3'h0)
    else $error("low result byte padding not zero");

  a_power_on: assert property (@(posedge clock) disable iff (!rst_n)
    (q.mode != ACC_IDLE) |-> adc_power)
    else $error("converter unpowered while converting");

  a_chan_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(acc_wr && paddr == ACC_CTL0_OFS) |=> $stable(adc_channel))
    else $error("channel changed without a control 0 write");

  a_buf_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(acc_wr && paddr == ACC_CTL1_OFS) |=> $stable(adc_buffer_cfg))
    else $error("buffer config changed without a control 1 write");

  a_ref_hi: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL1_OFS) |=> adc_ref_sel[1] == $past(pwdata[ACC_REFHI_BIT]))
    else $error("reference high bit not taken from control 1");

  a_ref_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_wr && paddr == ACC_CTL0_OFS && pwdata[ACC_REFPIN_BIT] && pwdata[ACC_REFLO_BIT])
    |=> adc_ref_out_en)
    else $error("reference not driven out when asked");

  a_cont_stay: assert property (@(posedge clock) disable iff (!rst_n)
    (q.mode == ACC_CONT && !acc_wr) |=> q.mode == ACC_CONT)
    else $error("continuous operation left without a write");
endmodule : acc_ctrl
`default_nettype wire

// ### acc_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Converter core stand-in
// ****************************************
module acc_adc_model
  import acc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic adc_power,
  input wire logic [3:0] adc_channel,
  input wire logic conv_done_irq,
  output logic [ACC_RES_W-1:0] adc_sample
);
  logic [8:0] n_q;
  logic [ACC_RES_W-1:0] junk_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      n_q <= 9'h000;
      junk_q <= 13'h1555;
    end else begin
      junk_q <= ~junk_q;
      if (conv_done_irq) begin
        n_q <= n_q + 9'h001;
      end
    end
  end
  // Unpowered core shows a toggling pattern, so a stale result cannot pass
  assign adc_sample = adc_power ? {adc_channel, 9'h0A5 + n_q} : junk_q;
endmodule : acc_adc_model
`default_nettype wire

// ### test_adc_continuous_conversion_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_continuous_conversion_ctrl
  import acc_pkg::*;
;
  localparam int FC = 20;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] adc_sample;
  logic [3:0] adc_channel;
  logic [2:0] adc_buffer_cfg;
  logic [1:0] adc_ref_sel;
  logic adc_power, adc_ref_out_en, conv_done_irq, prev_irq;
  int n_mismatch = 0, compares = 0, cyc = 0, n_irq = 0, irq_cyc, wr_cyc, c, w0;
  acc_ctrl #(.FIRST_CYC(FC)) u_acc_ctrl (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample), .adc_power(adc_power),
    .adc_channel(adc_channel), .adc_buffer_cfg(adc_buffer_cfg), .adc_ref_sel(adc_ref_sel),
    .adc_ref_out_en(adc_ref_out_en), .conv_done_irq(conv_done_irq));
  acc_adc_model u_acc_adc_model (.clock(clock), .rst_n(rst_n), .adc_power(adc_power),
    .adc_channel(adc_channel), .conv_done_irq(conv_done_irq), .adc_sample(adc_sample));
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    wr_cyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc
  // Returns the cycle of the next request, or -1 when none came in time
  task automatic wait_irq(input int lim);
    int k0;
    k0 = n_irq;
    c = -1;
    repeat (lim) begin
      @(posedge clock);
      if (n_irq != k0) begin
        c = irq_cyc;
        break;
      end
    end
  endtask : wait_irq
  task automatic res(input logic [3:0] ch, input int i, input logic pop);
    logic [12:0] s;
    s = {ch, 9'h0A5 + 9'(i)};
    rdc("res_hi", ACC_RES_HI_OFS, {24'h0, s[12:5]});
    rdc("res_lo", ACC_RES_LO_OFS, {24'h0, s[4:0], 3'h0});
    if (pop) rdc("fifo", ACC_FIFO_OFS, {1'b1, 18'h0, s});
  endtask : res
  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    prev_irq <= conv_done_irq;
    if (conv_done_irq === 1'b1) begin
      irq_cyc <= cyc;
      n_irq <= n_irq + 1;
    end
    if (conv_done_irq === 1'b1 && prev_irq === 1'b1) chk("irq_len", 0, 1);
  end
  initial begin
    #(50 * 40000);
    n_mismatch++;
    tally_and_finish();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} <= '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("outs", {adc_power, adc_ref_out_en, adc_ref_sel, conv_done_irq}, 0);
    rdc("ctl0", ACC_CTL0_OFS, 0);
    rdc("ctl1", ACC_CTL1_OFS, 0);
    rdc("stat", ACC_STAT_OFS, 32'h1);
    rdc("hole", 8'h18, 0);
    chk("err", er, 1);
    xfer(1'b1, 8'h1C, 32'hFF);
    chk("err", er, 1);
    xfer(1'b1, ACC_CTL1_OFS, 32'h85);
    xfer(1'b1, ACC_CTL0_OFS, 32'h3A);
    chk("buf", adc_buffer_cfg, 3'h5);
    chk("ref", adc_ref_sel, 2'h3);
    chk("chan", adc_channel, 4'hA);
    chk("refpin", adc_ref_out_en, 1);
    rdc("ctl0", ACC_CTL0_OFS, 32'h3A);
    xfer(1'b1, ACC_CTL1_OFS, 32'h05);
    chk("ref", adc_ref_sel, 2'h1);
    xfer(1'b1, ACC_CTL0_OFS, 32'h2A);
    chk("refpin", adc_ref_out_en, 0);
    // Continuous run from a powered-down converter
    xfer(1'b1, ACC_CTL0_OFS, 32'hC3);
    w0 = wr_cyc;
    chk("power", adc_power, 1);
    rdc("ctl0", ACC_CTL0_OFS, 32'hC3);
    rdc("stat", ACC_STAT_OFS, 32'h0A);
    wait_irq(FC + 200);
    chk("first", c - w0, FC + ACC_PWRUP_CYC + 1);
    rdc("ctl0", ACC_CTL0_OFS, 32'h43);
    res(4'h3, 0, 1'b1);
    for (int i = 1; i < 4; i++) begin
      w0 = c;
      wait_irq(400);
      chk("cadence", c - w0, ACC_REPEAT_CYC);
      rdc("ctl0", ACC_CTL0_OFS, 32'h43);
      res(4'h3, i, 1'b1);
    end
    xfer(1'b1, ACC_CTL1_OFS, 32'h0D);
    xfer(1'b1, ACC_CTL0_OFS, 32'h03);
    wait_irq(600);
    chk("stopped", c, -1);
    rdc("stat", ACC_STAT_OFS, 32'h09);
    // Single conversion, converter kept powered
    xfer(1'b1, ACC_CTL0_OFS, 32'h84);
    w0 = wr_cyc;
    wait_irq(FC + 200);
    chk("warm", c - w0, FC + 1);
    res(4'h4, 4, 1'b1);
    wait_irq(600);
    chk("single", c, -1);
    // Fill the buffer until it refuses
    xfer(1'b1, ACC_CTL1_OFS, 32'h05);
    xfer(1'b1, ACC_CTL0_OFS, 32'hC1);
    for (int i = 0; i < ACC_FIFO_DEPTH; i++) begin
      wait_irq(FC + 400);
      chk("fill", c == -1, 0);
    end
    wait_irq(600);
    chk("full", c, -1);
    rdc("stat", ACC_STAT_OFS, 32'h101C);
    xfer(1'b1, ACC_CTL0_OFS, 32'h01);
    for (int i = 0; i < ACC_FIFO_DEPTH; i++) begin
      rdc("fifo", ACC_FIFO_OFS, {1'b1, 18'h0, 4'h1, 9'h0A5 + 9'(5 + i)});
    end
    xfer(1'b0, ACC_FIFO_OFS, 0);
    chk("empty", rd[31], 0);
    wait_irq(600);
    chk("idle", c, -1);
    tally_and_finish();
  end
endmodule : test_adc_continuous_conversion_ctrl
`default_nettype wire
